// ===== verilog/part_pkg.sv
// package for the pwm auto-reload timer: register map, field positions, reset values
// assumes an axi4-lite slave with 32-bit data; 8-bit registers sit in the low byte
// Notes on behaviour
// [R1] 8-bit counter increments on prescaled clock
// [R2] overflow reloads counter, prescaler untouched
// [R3] software reads/writes live counter anytime
// [R4] 7-bit prescaler, divide by 2^n
// [R5] prescaler input cpu or external clock
// [R6] run bit clear freezes prescaler, counter
// [R7] reset: zeros, cpu clock selected
// [R8] force reload or counter write clears prescaler
// [R9] compare shadow loaded from duty at overflow
// [R10] output enable drives pwm pin
// [R11] common pwm period 256 minus reload
// [R12] overflow sets polarity level, compare restores
// [R13] software keeps compare above reload value
// [R14] overflow sets flag, irq when enabled
// [R15] event mode: overflow after 256-reload events
// [R16] halt with external clock: freeze, keep counting
// [R17] software clears run before halt
// [R18] capture edge copies counter, sets flag
// [R19] capture blocked until status read
// [R20] capture irq while flag and enable
// [R21] halt stops pwm and capture, wake stays
// [R22] capture events synchronized to counter clock
// [R23] status read clears overflow flag
// [R24] force reload bit reads zero
// [R25] duty ffh gives 0, 00h gives 1
// [R26] edge select: 0 falling, 1 rising
// [R27] overflow is increment from ffh
package part_pkg;
	// ==========================================
	// register byte addresses
	localparam logic [7:0] PART_DUTY1_ADDR = 8'h00;
	localparam logic [7:0] PART_DUTY0_ADDR = 8'h04;
	localparam logic [7:0] PART_PWM_CONTROL_REG_ADDR = 8'h08;
	localparam logic [7:0] PART_CSR_ADDR = 8'h0c;
	localparam logic [7:0] PART_CAR_ADDR = 8'h10;
	localparam logic [7:0] PART_ARR_ADDR = 8'h14;
	localparam logic [7:0] PART_CAPTURE_CTRL_STATUS_REG_ADDR = 8'h18;
	localparam logic [7:0] PART_ICR0_ADDR = 8'h1c;
	localparam logic [7:0] PART_ICR1_ADDR = 8'h20;
	// ==========================================
	// field positions
	localparam int PART_CSR_EXT_CLOCK_SELECT = 7;
	localparam int PART_CSR_CC = 4;
	localparam int PART_CSR_RUN = 3;
	localparam int PART_CSR_FORCE_RELOAD = 2;
	localparam int PART_CSR_OIE = 1;
	localparam int PART_CSR_OVF = 0;
	localparam int PART_PWM_OE = 4;
	localparam int PART_PWM_OP = 0;
	localparam int PART_IC_CS = 4;
	localparam int PART_IC_CIE = 2;
	localparam int PART_IC_CF = 0;
	// ==========================================
	// values
	localparam logic [7:0] PART_RESET_BYTE = 8'h00;
	localparam logic [6:0] PART_PRESC_RESET = 7'h00;
	localparam logic [7:0] PART_CNT_MAX = 8'hff;
	localparam logic [7:0] PART_DUTY_LOW = 8'hff;
	localparam logic [7:0] PART_DUTY_HIGH = 8'h00;
	localparam logic [1:0] PART_RESP_OKAY = 2'b00;
	localparam logic [1:0] PART_RESP_SLVERR = 2'b10;
	// ==========================================
	// pin groups
	typedef struct packed {
		logic [1:0] o;
		logic [1:0] oe;
	} part_pwm_t;
	typedef struct packed {
		logic ovf_irq;
		logic [1:0] cap_irq;
		logic wake;
	} part_irq_t;
endpackage

// ===== verilog/part_timer.sv
// pwm auto-reload timer with axi4-lite register slave
// assumes aclk is the cpu clock; pins come from outside and are synchronised here
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module part_timer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins and system
	input wire logic external_event_clock,
	input wire logic [1:0] capture_input_pin,
	input wire logic halt_mode,
	output part_pkg::part_pwm_t pwm_output_pin,
	output part_pkg::part_irq_t irq
);
	import part_pkg::*;

	// ==========================================
	// registers
	logic [7:0] counter;
	logic [6:0] presc;
	logic [7:0] auto_reload_value;
	logic [7:0] duty_cycle_value [2];
	logic [7:0] compare_shadow [2];
	logic [7:0] capture_value [2];
	logic [1:0] pwm_out_on, pwm_polarity, capture_irq_on, capture_edge_select, capture_flag;
	logic [1:0] pwm_level;
	logic ext_clock_select, counter_run, overflow_irq_on, overflow_flag;
	logic [2:0] prescale_select;
	logic [2:0] ext_sync;
	logic [1:0] cap_s1, cap_s2, cap_prev, cap_pend;

	// ==========================================
	// bus handshake
	logic aw_held, w_held, wr_go, rd_go;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0;
			ws_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// write decode
	logic wr_ok, wb;
	logic [7:0] wd;
	assign wb = ws_q[0];
	assign wd = w_q[7:0];
	always_comb begin
		case (aw_q)
			PART_DUTY1_ADDR, PART_DUTY0_ADDR, PART_PWM_CONTROL_REG_ADDR, PART_CSR_ADDR, PART_CAR_ADDR,
			PART_ARR_ADDR, PART_CAPTURE_CTRL_STATUS_REG_ADDR, PART_ICR0_ADDR, PART_ICR1_ADDR: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	logic wr_csr, wr_car, wr_arr, wr_pwm_control_reg, wr_capture_ctrl_status_reg, wr_d0, wr_d1;
	assign wr_csr = wr_go && wb && aw_q == PART_CSR_ADDR;
	assign wr_car = wr_go && wb && aw_q == PART_CAR_ADDR;
	assign wr_arr = wr_go && wb && aw_q == PART_ARR_ADDR;
	assign wr_pwm_control_reg = wr_go && wb && aw_q == PART_PWM_CONTROL_REG_ADDR;
	assign wr_capture_ctrl_status_reg = wr_go && wb && aw_q == PART_CAPTURE_CTRL_STATUS_REG_ADDR;
	assign wr_d0 = wr_go && wb && aw_q == PART_DUTY0_ADDR;
	assign wr_d1 = wr_go && wb && aw_q == PART_DUTY1_ADDR;

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PART_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? PART_RESP_OKAY : PART_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// control registers
	// [R16] frozen in halt when external clock selected
	logic ctl_frz;
	assign ctl_frz = halt_mode && ext_clock_select;
	always_ff @(posedge aclk) begin
		// [R7] reset selects cpu clock
		if (!aresetn) begin
			ext_clock_select <= 1'b0;
			prescale_select <= 3'h0;
			counter_run <= 1'b0;
			overflow_irq_on <= 1'b0;
			auto_reload_value <= PART_RESET_BYTE;
			pwm_out_on <= 2'b00;
			pwm_polarity <= 2'b00;
			capture_irq_on <= 2'b00;
			capture_edge_select <= 2'b00;
			duty_cycle_value[0] <= PART_RESET_BYTE;
			duty_cycle_value[1] <= PART_RESET_BYTE;
		end else if (!ctl_frz) begin
			if (wr_csr) begin
				ext_clock_select <= wd[PART_CSR_EXT_CLOCK_SELECT];
				prescale_select <= wd[PART_CSR_CC +: 3];
				counter_run <= wd[PART_CSR_RUN];
				overflow_irq_on <= wd[PART_CSR_OIE];
			end
			if (wr_arr) auto_reload_value <= wd;
			if (wr_pwm_control_reg) begin
				pwm_out_on <= wd[PART_PWM_OE +: 2];
				pwm_polarity <= wd[PART_PWM_OP +: 2];
			end
			if (wr_capture_ctrl_status_reg) begin
				capture_edge_select <= wd[PART_IC_CS +: 2];
				capture_irq_on <= wd[PART_IC_CIE +: 2];
			end
			if (wr_d0) duty_cycle_value[0] <= wd;
			if (wr_d1) duty_cycle_value[1] <= wd;
		end
	end

	// ==========================================
	// clock source and prescaler
	// [R5] external clock synchronised, rising edge used
	always_ff @(posedge aclk) begin
		if (!aresetn) ext_sync <= 3'b000;
		else ext_sync <= {ext_sync[1:0], external_event_clock};
	end
	logic in_tick, cnt_tick, force_ld, ovf_ev;
	logic [7:0] presc_ext;
	logic [6:0] tap_mask;
	assign in_tick = ext_clock_select ? (ext_sync[1] && !ext_sync[2]) : 1'b1;
	// [R4] tap of 2^n: tick when the low n bits wrap
	assign presc_ext = {1'b0, presc} + 8'h01;
	// low n bits all ones means carry into bit n on this input tick
	assign tap_mask = 7'((8'h01 << prescale_select) - 8'h01);
	assign cnt_tick = counter_run && in_tick && ((presc & tap_mask) == tap_mask);
	// [R8] force reload needs run bit with it
	assign force_ld = wr_csr && !ctl_frz && wd[PART_CSR_FORCE_RELOAD] && wd[PART_CSR_RUN];
	// [R27] overflow is tick while at ffh
	assign ovf_ev = cnt_tick && counter == PART_CNT_MAX;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= PART_PRESC_RESET;
		// [R8] either initialisation clears prescaler
		end else if (force_ld || wr_car) begin
			presc <= PART_PRESC_RESET;
		// [R6] frozen when run bit clear
		end else if (counter_run && in_tick) begin
			presc <= presc_ext[6:0];
		end
	end

	// ==========================================
	// counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter <= PART_RESET_BYTE;
		// [R3] write on the fly
		end else if (wr_car) begin
			counter <= wd;
		end else if (force_ld) begin
			counter <= auto_reload_value;
		// [R2] reload, prescaler keeps running
		end else if (ovf_ev) begin
			counter <= auto_reload_value;
		// [R1] increment on prescaled tick
		end else if (cnt_tick) begin
			counter <= counter + 8'h01;
		end
	end

	// ==========================================
	// overflow flag, read clear
	logic rd_csr, rd_capture_ctrl_status_reg;
	assign rd_csr = rd_go && s_axi_araddr == PART_CSR_ADDR;
	assign rd_capture_ctrl_status_reg = rd_go && s_axi_araddr == PART_CAPTURE_CTRL_STATUS_REG_ADDR;
	always_ff @(posedge aclk) begin
		if (!aresetn) overflow_flag <= 1'b0;
		// [R14] [R15] set on each overflow, set wins
		else if (ovf_ev) overflow_flag <= 1'b1;
		// [R23] cleared by status read
		else if (rd_csr) overflow_flag <= 1'b0;
	end

	// ==========================================
	// pwm channels and capture channels
	logic [1:0] cap_fire;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			// [R9] shadow loaded only at overflow
			always_ff @(posedge aclk) begin
				if (!aresetn) compare_shadow[g] <= PART_RESET_BYTE;
				else if (ovf_ev && !halt_mode) compare_shadow[g] <= duty_cycle_value[g];
			end
			// [R11] [R12] level set at overflow, cleared at compare
			always_ff @(posedge aclk) begin
				if (!aresetn) pwm_level[g] <= 1'b0;
				else if (halt_mode) pwm_level[g] <= pwm_level[g];
				else if (ovf_ev) pwm_level[g] <= 1'b1;
				else if (cnt_tick && counter + 8'h01 == compare_shadow[g]) pwm_level[g] <= 1'b0;
			end
			// [R10] [R25] enable, duty extremes, polarity
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pwm_output_pin.o[g] <= 1'b0;
					pwm_output_pin.oe[g] <= 1'b0;
				end else begin
					pwm_output_pin.oe[g] <= pwm_out_on[g];
					if (compare_shadow[g] == PART_DUTY_LOW) pwm_output_pin.o[g] <= 1'b0;
					else if (compare_shadow[g] == PART_DUTY_HIGH) pwm_output_pin.o[g] <= 1'b1;
					else pwm_output_pin.o[g] <= pwm_level[g] ^ pwm_polarity[g];
				end
			end
			// pin synchroniser and edge history
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cap_s1[g] <= 1'b0;
					cap_s2[g] <= 1'b0;
					cap_prev[g] <= 1'b0;
				end else begin
					cap_s1[g] <= capture_input_pin[g];
					cap_s2[g] <= cap_s1[g];
					cap_prev[g] <= cap_s2[g];
				end
			end
			// [R26] edge choice; [R22] held until counter tick or halt
			always_ff @(posedge aclk) begin
				if (!aresetn) cap_pend[g] <= 1'b0;
				else if ((capture_edge_select[g] ? (cap_s2[g] && !cap_prev[g]) : (!cap_s2[g] && cap_prev[g])))
					cap_pend[g] <= 1'b1;
				else if (cnt_tick || halt_mode) cap_pend[g] <= 1'b0;
			end
			assign cap_fire[g] = cap_pend[g] && (cnt_tick || halt_mode);
			// [R18] [R19] [R21] latch when free and not halted
			always_ff @(posedge aclk) begin
				if (!aresetn) capture_value[g] <= PART_RESET_BYTE;
				else if (cap_fire[g] && !capture_flag[g] && !halt_mode) capture_value[g] <= counter;
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) capture_flag[g] <= 1'b0;
				else if (cap_fire[g]) capture_flag[g] <= 1'b1;
				else if (rd_capture_ctrl_status_reg) capture_flag[g] <= 1'b0;
			end
		end
	endgenerate

	// ==========================================
	// interrupt requests
	always_comb begin
		irq.ovf_irq = overflow_flag && overflow_irq_on;
		// [R20] level while flag and enable
		irq.cap_irq = capture_flag & capture_irq_on;
		// [R16] [R21] wake from halt
		irq.wake = halt_mode && (irq.ovf_irq || (|irq.cap_irq));
	end

	// ==========================================
	// read path
	logic [7:0] rbyte;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			PART_DUTY1_ADDR: rbyte = duty_cycle_value[1];
			PART_DUTY0_ADDR: rbyte = duty_cycle_value[0];
			PART_PWM_CONTROL_REG_ADDR: rbyte = {2'b00, pwm_out_on, 2'b00, pwm_polarity};
			// [R24] force reload reads zero
			PART_CSR_ADDR: rbyte = {ext_clock_select, prescale_select, counter_run, 1'b0,
				overflow_irq_on, overflow_flag};
			PART_CAR_ADDR: rbyte = counter;
			PART_ARR_ADDR: rbyte = auto_reload_value;
			PART_CAPTURE_CTRL_STATUS_REG_ADDR: rbyte = {2'b00, capture_edge_select, capture_irq_on, capture_flag};
			PART_ICR0_ADDR: rbyte = capture_value[0];
			PART_ICR1_ADDR: rbyte = capture_value[1];
			default: begin
				rbyte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= PART_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rbyte};
			s_axi_rresp <= rd_ok ? PART_RESP_OKAY : PART_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== tb/part_timer_properties.sv
// checker for part_timer: bus answers, reset levels, capture irq, halt
// assumes bind onto part_timer with one aclk domain
`timescale 1ns/10ps
module part_timer_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins
	input wire logic halt_mode,
	input wire part_pkg::part_pwm_t pwm_output_pin,
	input wire part_pkg::part_irq_t irq
);
	import part_pkg::*;
	logic [7:0] rd_addr;
	logic wr_pend;
	logic ar_go;
	// =========
	// helpers: last read address, write in flight
	assign ar_go = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (ar_go) rd_addr <= s_axi_araddr;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || s_axi_bvalid) wr_pend <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready) wr_pend <= 1'b1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// =========
	// assertions
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed early");
	AST_R_LAT: assert property (ar_go |=> s_axi_rvalid)
		else $error("read answer late");
	AST_W_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_FORCE_RELOAD_ZERO: assert property (s_axi_rvalid && rd_addr == PART_CSR_ADDR |-> !s_axi_rdata[PART_CSR_FORCE_RELOAD])
		else $error("force reload bit read as one");
	AST_RST_OUT: assert property (disable iff (1'b0) !aresetn |=> pwm_output_pin == '0 && irq.cap_irq == 2'b00)
		else $error("outputs not clear after reset");
	AST_CAP_IRQ: assert property (irq.cap_irq[0] && !ar_go && !s_axi_awvalid && !wr_pend |=> irq.cap_irq[0])
		else $error("capture irq dropped");
	AST_HALT_PWM: assert property (halt_mode [*3] ##0 !s_axi_awvalid && !wr_pend |=> $stable(pwm_output_pin.o))
		else $error("pwm moved in halt");
	// covers
	cover property (ar_go && s_axi_araddr == PART_CAPTURE_CTRL_STATUS_REG_ADDR);
	cover property (irq.wake);
	cover property ($rose(pwm_output_pin.o[0]));
endmodule
bind part_timer part_timer_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .halt_mode(halt_mode),
	.pwm_output_pin(pwm_output_pin), .irq(irq));

// ===== tb/part_pins.sv
// pin model: event clock and capture inputs
// assumes the bench calls its tasks; event clock idles low
`timescale 1ns/10ps
module part_pins (
	// clock
	input wire logic aclk,
	// pins
	output logic external_event_clock,
	output logic [1:0] capture_input_pin
);
	// =========
	// idle levels
	initial begin
		external_event_clock = 1'b0;
		capture_input_pin = 2'b11;
	end
	// events: 4 cycles high, 4 low, then still
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge aclk);
			external_event_clock <= 1'b1;
			repeat (4) @(posedge aclk);
			external_event_clock <= 1'b0;
			repeat (4) @(posedge aclk);
		end
		@(negedge aclk);
	endtask
	// capture level, held past the synchroniser
	task automatic set_cap(input int ch, input logic v);
		@(posedge aclk);
		capture_input_pin[ch] <= v;
		repeat (4) @(posedge aclk);
	endtask
endmodule

// ===== tb/tb.sv
// bench for part_timer: bus tasks, scenarios, verdict
// assumes part_pins on the pins and the bound checker
`timescale 1ns/10ps
module tb;
	import part_pkg::*;
	logic aclk, aresetn, awv, wv, bready, arv, rready, halt;
	logic awrdy, wrdy, bvalid, arrdy, rvalid, evclk;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, d, v1;
	logic [1:0] bresp, rresp, r, cap;
	part_pwm_t pwm;
	part_irq_t irq;
	int errors, check_count, cycles;
	part_timer u_part_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
		.s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .external_event_clock(evclk),
		.capture_input_pin(cap), .halt_mode(halt), .pwm_output_pin(pwm), .irq(irq));
	part_pins u_part_pins (.aclk(aclk), .external_event_clock(evclk), .capture_input_pin(cap));
	// =========
	// clock and hang limit
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// =========
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic pa, pw, t;
		pa = 1'b1;
		pw = 1'b1;
		t = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			pa = pa && !awrdy;
			pw = pw && !wrdy;
			@(posedge aclk);
			awv <= pa;
			wv <= pw;
		end
		while (!t) begin
			@(negedge aclk);
			t = bvalid;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic t;
		t = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		while (!t) begin
			@(negedge aclk);
			t = arrdy;
			@(posedge aclk);
		end
		arv <= 1'b0;
		t = 1'b0;
		while (!t) begin
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask
	task automatic rck(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(d, {24'h0, e});
	endtask
	// =========
	// scenarios
	task automatic t_reset();
		rck(PART_CSR_ADDR, 8'h00);
		rck(PART_CAR_ADDR, 8'h00);
		// a write without the low byte lane is ignored
		wstrb <= 4'he;
		wr(PART_ARR_ADDR, 8'h55);
		wstrb <= 4'hf;
		rck(PART_ARR_ADDR, 8'h00);
		rd(8'h24);
		chk({30'h0, r}, {30'h0, PART_RESP_SLVERR});
	endtask
	task automatic t_event();
		wr(PART_ARR_ADDR, 8'hfd);
		wr(PART_CAR_ADDR, 8'hfd);
		wr(PART_CSR_ADDR, 8'h88);
		u_part_pins.pulse(2);
		rck(PART_CAR_ADDR, 8'hff);
		rck(PART_CSR_ADDR, 8'h88);
		u_part_pins.pulse(1);
		rck(PART_CAR_ADDR, 8'hfd);
		rck(PART_CSR_ADDR, 8'h89);
		rck(PART_CSR_ADDR, 8'h88);
		wr(PART_CSR_ADDR, 8'h80);
		u_part_pins.pulse(1);
		rck(PART_CAR_ADDR, 8'hfd);
		wr(PART_CSR_ADDR, 8'h98);
		wr(PART_CAR_ADDR, 8'hfb);
		u_part_pins.pulse(2);
		rck(PART_CAR_ADDR, 8'hfc);
		wr(PART_CSR_ADDR, 8'h8c);
		rck(PART_CAR_ADDR, 8'hfd);
		rck(PART_CSR_ADDR, 8'h88);
	endtask
	task automatic t_pwm();
		wr(PART_DUTY0_ADDR, 8'hfe);
		wr(PART_DUTY1_ADDR, 8'hff);
		wr(PART_PWM_CONTROL_REG_ADDR, 8'h30);
		wr(PART_CAR_ADDR, 8'hff);
		u_part_pins.pulse(1);
		chk({28'h0, pwm}, 32'h7);
		u_part_pins.pulse(1);
		chk({28'h0, pwm}, 32'h3);
		u_part_pins.pulse(2);
		chk({28'h0, pwm}, 32'h7);
		wr(PART_DUTY1_ADDR, 8'h00);
		wr(PART_PWM_CONTROL_REG_ADDR, 8'h31);
		repeat (2) @(negedge aclk);
		chk({28'h0, pwm}, 32'h3);
		u_part_pins.pulse(3);
		chk({28'h0, pwm}, 32'hb);
	endtask
	task automatic t_cap();
		wr(PART_CAPTURE_CTRL_STATUS_REG_ADDR, 8'h14);
		u_part_pins.set_cap(0, 1'b0);
		u_part_pins.pulse(1);
		chk({30'h0, irq.cap_irq}, 32'h0);
		u_part_pins.set_cap(0, 1'b1);
		u_part_pins.pulse(1);
		chk({30'h0, irq.cap_irq}, 32'h1);
		rd(PART_ICR0_ADDR);
		v1 = d;
		u_part_pins.set_cap(1, 1'b0);
		u_part_pins.set_cap(0, 1'b0);
		u_part_pins.set_cap(0, 1'b1);
		u_part_pins.pulse(1);
		wr(PART_ICR0_ADDR, 8'h5a);
		rck(PART_ICR0_ADDR, v1[7:0]);
		rck(PART_CAPTURE_CTRL_STATUS_REG_ADDR, 8'h17);
		@(negedge aclk);
		chk({30'h0, irq.cap_irq}, 32'h0);
		rck(PART_CAPTURE_CTRL_STATUS_REG_ADDR, 8'h14);
	endtask
	task automatic t_halt();
		wr(PART_CSR_ADDR, 8'h8a);
		wr(PART_CAR_ADDR, 8'hff);
		halt <= 1'b1;
		// run clear attempted in halt: frozen, ignored
		wr(PART_CSR_ADDR, 8'h00);
		u_part_pins.pulse(1);
		chk({30'h0, irq.ovf_irq, irq.wake}, 32'h3);
		@(posedge aclk);
		halt <= 1'b0;
		rck(PART_CSR_ADDR, 8'h8b);
	endtask
	// =========
	// main sequence
	initial begin
		aresetn = 1'b0;
		awv = 1'b0;
		wv = 1'b0;
		bready = 1'b0;
		arv = 1'b0;
		rready = 1'b0;
		halt = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		cycles = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_event();
		t_pwm();
		t_cap();
		t_halt();
		summarize();
	end
endmodule
